//--- pkg/csc_pkg.sv
// Package for the channel sequence configuration bank: map, layouts, resets, modes
`default_nettype none

package csc_pkg;

   // Bus widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int BE_W   = 4;
   localparam int CFG_W  = 24;

   // Channel count and channel number width
   localparam int NUM_CHAN = 16;
   localparam int CHAN_W   = 4;

   // Register indexes; byte address is four times the index
   localparam logic [5:0] IDX_CHAN_FIRST = 6'h09;
   localparam logic [5:0] IDX_CHAN_LAST  = 6'h18;
   localparam logic [5:0] IDX_STATUS     = 6'h20;
   localparam logic [5:0] IDX_CTRL       = 6'h21;
   localparam int         IDX_LSB        = 2;

   // Reset values
   localparam logic [CFG_W-1:0]  CFG_RST_CH0 = 24'h800100;
   localparam logic [CFG_W-1:0]  CFG_RST     = 24'h000100;
   localparam logic [DATA_W-1:0] CTRL_RST    = 32'h00000000;

   // Byte lane geometry of a channel register
   localparam int CFG_BYTES = 3;
   localparam int BYTE_W    = 8;

   // Avalon-MM response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // Device power modes
   typedef enum logic [1:0] {
      MODE_ACTIVE  = 2'h0,
      MODE_STANDBY = 2'h1,
      MODE_PDOWN   = 2'h2,
      MODE_PDOWN_A = 2'h3
   } csc_mode_e;

   // One channel configuration register, bit 23 down to bit 0
   typedef struct packed {
      logic        enable;
      logic [2:0]  setup_sel;
      logic        low_side_switch_on;
      logic        threshold_watch_enable;
      logic [4:0]  positive_input_select;
      logic [12:0] other_fields;
   } csc_chan_s;

   // Control register
   typedef struct packed {
      logic [26:0] reserved;
      logic        restart;
      logic        fifo_enable;
      logic        standby_switch_keep;
      csc_mode_e   mode;
   } csc_ctrl_s;

   // Status register: current channel above last result channel
   typedef struct packed {
      logic [CHAN_W-1:0] cur_chan;
      logic [CHAN_W-1:0] result_chan;
   } csc_status_s;

   // Settings applied to the converter for the channel in progress
   typedef struct packed {
      logic              valid;
      logic [CHAN_W-1:0] chan;
      logic [2:0]        setup_sel;
      logic [4:0]        positive_input_select;
      logic              threshold_watch_enable;
   } csc_apply_s;

endpackage : csc_pkg

`default_nettype wire

//--- rtl/csc_top.sv
// Channel configuration bank and automatic channel sequencer with Avalon-MM access
`timescale 1ns/10ps
`default_nettype none

module csc_top (
   // Clock and reset
   input  wire logic                         ref_clk_i,
   input  wire logic                         resetn_i,
   // Avalon-MM slave
   input  wire logic [csc_pkg::ADDR_W-1:0]   avs_address_i,
   input  wire logic                         avs_read_i,
   input  wire logic                         avs_write_i,
   input  wire logic [csc_pkg::DATA_W-1:0]   avs_writedata_i,
   input  wire logic [csc_pkg::BE_W-1:0]     avs_byteenable_i,
   output var  logic [csc_pkg::DATA_W-1:0]   avs_readdata_o,
   output var  logic [1:0]                   avs_response_o,
   output var  logic                         avs_waitrequest_o,
   // Converter side
   input  wire logic                         conv_done_i,
   output var  csc_pkg::csc_apply_s          apply_o,
   output var  logic                         low_side_switch_on_o
);

   import csc_pkg::*;

   // Bus slave state
   logic              ack_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic [1:0]        resp_reg;
   logic [1:0]        resp_next;

   // Register file
   csc_chan_s         cfg_reg [NUM_CHAN];
   csc_ctrl_s         ctrl_reg;
   logic [CHAN_W-1:0] last_reg;

   // Sequencer
   logic [CHAN_W-1:0] cur_reg;
   logic [CHAN_W-1:0] cur_next;
   csc_apply_s        apply_reg;
   csc_apply_s        apply_next;
   logic              sw_reg;
   logic              sw_next;

   // Decode
   logic [5:0]        word_idx;
   logic [CHAN_W-1:0] chan_idx;
   logic              hit_chan;
   logic              hit_status;
   logic              hit_ctrl;
   logic              req;
   logic              wr_fire;
   logic              restart_req;
   csc_ctrl_s         wr_ctrl;
   logic              conv_fire;
   logic [NUM_CHAN-1:0] en_vec;
   csc_chan_s         cur_cfg;
   csc_status_s       status;

   // Smallest enabled channel above cur, else the lowest enabled one
   function automatic logic [CHAN_W-1:0] next_chan(
      input logic [NUM_CHAN-1:0] en,
      input logic [CHAN_W-1:0]   cur
   );
      logic [CHAN_W-1:0] lo;
      logic [CHAN_W-1:0] hi;
      logic              found;
      lo    = '0;
      hi    = '0;
      found = 1'b0;
      for (int i = NUM_CHAN - 1; i >= 0; i--) begin
         if (en[i]) begin
            lo = CHAN_W'(i);
            if (i > int'(cur)) begin
               hi    = CHAN_W'(i);
               found = 1'b1;
            end
         end
      end
      return found ? hi : lo;
   endfunction : next_chan

   // Byte lane merge; lane 3 has no storage and is dropped
   function automatic csc_chan_s merge_cfg(
      input csc_chan_s         old_val,
      input logic [DATA_W-1:0] wd,
      input logic [BE_W-1:0]   be
   );
      logic [CFG_W-1:0] v;
      v = old_val;
      for (int b = 0; b < CFG_BYTES; b++) begin
         if (be[b]) begin
            v[b*BYTE_W +: BYTE_W] = wd[b*BYTE_W +: BYTE_W];
         end
      end
      return csc_chan_s'(v);
   endfunction : merge_cfg

   // Address decode
   assign word_idx   = avs_address_i[IDX_LSB +: 6];
   assign chan_idx   = CHAN_W'(word_idx - IDX_CHAN_FIRST);
   assign hit_chan   = (word_idx >= IDX_CHAN_FIRST) &&
                       (word_idx <= IDX_CHAN_LAST);
   assign hit_status = (word_idx == IDX_STATUS);
   assign hit_ctrl   = (word_idx == IDX_CTRL);

   // One wait state: request seen, then answered on the following cycle
   assign req               = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~ack_reg;
   assign wr_fire           = avs_write_i & ack_reg;
   assign avs_readdata_o    = rdata_reg;
   assign avs_response_o    = resp_reg;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req & ~ack_reg;
      end
   end

   // Read data and response captured in the wait cycle
   always_comb begin
      rdata_next = '0;
      resp_next  = RESP_OKAY;
      if (hit_chan) begin
         rdata_next = DATA_W'(cfg_reg[chan_idx]);
      end else if (hit_status) begin
         rdata_next = DATA_W'(status);
      end else if (hit_ctrl) begin
         rdata_next = DATA_W'(ctrl_reg);
      end else begin
         resp_next = RESP_DECERR;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_reg <= '0;
         resp_reg  <= RESP_OKAY;
      end else if (req && !ack_reg) begin
         rdata_reg <= avs_read_i ? rdata_next : '0;
         resp_reg  <= resp_next;
      end
   end

   // Channel configuration registers
   for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            cfg_reg[g] <= (g == 0) ? csc_chan_s'(CFG_RST_CH0)
                                   : csc_chan_s'(CFG_RST);
         end else if (wr_fire && hit_chan && chan_idx == CHAN_W'(g)) begin
            cfg_reg[g] <= merge_cfg(cfg_reg[g], avs_writedata_i,
                                    avs_byteenable_i);
         end
      end
      assign en_vec[g] = cfg_reg[g].enable;
   end

   // Control register; restart is a write-one action and reads back zero
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_reg <= csc_ctrl_s'(CTRL_RST);
      end else if (wr_fire && hit_ctrl && avs_byteenable_i[0]) begin
         ctrl_reg          <= csc_ctrl_s'(avs_writedata_i);
         ctrl_reg.reserved <= '0;
         ctrl_reg.restart  <= 1'b0;
      end
   end

   // Field view of the write word, so the restart bit is picked by name
   assign wr_ctrl     = csc_ctrl_s'(avs_writedata_i);
   assign restart_req = wr_fire && hit_ctrl && avs_byteenable_i[0] && wr_ctrl.restart;

   // Results only arrive while converting with something enabled
   assign conv_fire = conv_done_i && (ctrl_reg.mode == MODE_ACTIVE) &&
                      (|en_vec);

   // Sequencer position
   always_comb begin
      cur_next = cur_reg;
      if (restart_req) begin
         cur_next = next_chan(en_vec, '1);
      end else if (conv_fire) begin
         cur_next = next_chan(en_vec, cur_reg);
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cur_reg <= '0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   // Channel of the last written result
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         last_reg <= '0;
      end else if (conv_fire) begin
         last_reg <= cur_reg;
      end
   end

   assign status.cur_chan    = cur_reg;
   assign status.result_chan = last_reg;

   // Settings of the channel in progress
   assign cur_cfg = cfg_reg[cur_reg];

   always_comb begin
      apply_next.valid     = cur_cfg.enable;
      apply_next.chan      = cur_reg;
      apply_next.setup_sel = cur_cfg.setup_sel;
      apply_next.positive_input_select = cur_cfg.positive_input_select;
      apply_next.threshold_watch_enable =
         cur_cfg.threshold_watch_enable & ctrl_reg.fifo_enable;
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         apply_reg <= '0;
      end else begin
         apply_reg <= apply_next;
      end
   end

   assign apply_o = apply_reg;

   // Low-side switch; a disabled channel never holds it closed
   always_comb begin
      sw_next = 1'b0;
      case (ctrl_reg.mode)
         MODE_ACTIVE: begin
            sw_next = cur_cfg.enable & cur_cfg.low_side_switch_on;
         end
         MODE_STANDBY: begin
            sw_next = ctrl_reg.standby_switch_keep & cur_cfg.enable &
                      cur_cfg.low_side_switch_on;
         end
         default: begin
            sw_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sw_reg <= 1'b0;
      end else begin
         sw_reg <= sw_next;
      end
   end

   assign low_side_switch_on_o = sw_reg;

endmodule : csc_top

`default_nettype wire

//--- sim/csc_checker.sv
// Concurrent checks on the channel bank ports
`timescale 1ns/10ps
`default_nettype none
module csc_checker (
   // Clock and reset
   input wire logic                       ref_clk_i,
   input wire logic                       resetn_i,
   // Avalon-MM slave
   input wire logic [csc_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic                       avs_read_i,
   input wire logic                       avs_write_i,
   input wire logic [csc_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [csc_pkg::BE_W-1:0]   avs_byteenable_i,
   input wire logic [csc_pkg::DATA_W-1:0] avs_readdata_o,
   input wire logic [1:0]                 avs_response_o,
   input wire logic                       avs_waitrequest_o,
   // Converter side
   input wire logic                       conv_done_i,
   input wire csc_pkg::csc_apply_s        apply_o,
   input wire logic                       low_side_switch_on_o
);
   import csc_pkg::*;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   logic [5:0] idx;
   logic       ctrl_wr;
   logic       mapped;
   logic [1:0] mode_q;
   logic       keep_q;
   logic       fifo_q;
   assign idx = avs_address_i[7:2];
   assign ctrl_wr = avs_write_i && !avs_waitrequest_o && idx == IDX_CTRL && avs_byteenable_i[0];
   assign mapped = (idx >= IDX_CHAN_FIRST && idx <= IDX_CHAN_LAST) || idx == IDX_STATUS
                   || idx == IDX_CTRL;
   // Shadow of the mode bits, so power rules can be judged from the ports alone
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_q <= 2'h0;
         keep_q <= 1'b0;
         fifo_q <= 1'b0;
      end else if (ctrl_wr) begin
         mode_q <= avs_writedata_i[1:0];
         keep_q <= avs_writedata_i[2];
         fifo_q <= avs_writedata_i[3];
      end
   end
   property p_one_wait;
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("wait too long");
   property p_idle;
      !(avs_read_i || avs_write_i) |-> !avs_waitrequest_o;
   endproperty
   a_idle: assert property (p_idle) else $error("wait while idle");
   property p_unmapped;
      avs_read_i && !avs_waitrequest_o && !mapped |->
         avs_response_o == RESP_DECERR && avs_readdata_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_chan_read;
      avs_read_i && !avs_waitrequest_o && idx >= IDX_CHAN_FIRST && idx <= IDX_CHAN_LAST |->
         avs_response_o == RESP_OKAY && avs_readdata_o[31:24] == 8'h0;
   endproperty
   a_chan_read: assert property (p_chan_read) else $error("channel read");
   property p_pdown;
      mode_q[1] |=> !low_side_switch_on_o;
   endproperty
   a_pdown: assert property (p_pdown) else $error("switch in power-down");
   property p_standby;
      mode_q == MODE_STANDBY && !keep_q |=> !low_side_switch_on_o;
   endproperty
   a_standby: assert property (p_standby) else $error("switch in standby");
   property p_sw_valid;
      low_side_switch_on_o |-> apply_o.valid;
   endproperty
   a_sw_valid: assert property (p_sw_valid) else $error("switch on idle channel");
   property p_thr;
      apply_o.threshold_watch_enable |-> $past(fifo_q);
   endproperty
   a_thr: assert property (p_thr) else $error("threshold without fifo");
   property p_hold;
      conv_done_i && mode_q != 2'h0 && !avs_write_i |=> ##1 $stable(apply_o.chan);
   endproperty
   a_hold: assert property (p_hold) else $error("advance outside active");
   property p_advance;
      conv_done_i && mode_q == 2'h0 && apply_o.valid && !avs_write_i |=> ##1 apply_o.valid;
   endproperty
   a_advance: assert property (p_advance) else $error("advance to idle channel");
endmodule : csc_checker
bind csc_top csc_checker csc_checker_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
   .avs_readdata_o(avs_readdata_o), .avs_response_o(avs_response_o),
   .avs_waitrequest_o(avs_waitrequest_o), .conv_done_i(conv_done_i), .apply_o(apply_o),
   .low_side_switch_on_o(low_side_switch_on_o));
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the channel configuration bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import csc_pkg::*;
   logic              ref_clk_i, resetn_i, avs_read_i, avs_write_i, conv_done_i;
   logic [ADDR_W-1:0] avs_address_i;
   logic [DATA_W-1:0] avs_writedata_i, avs_readdata_o, d;
   logic [BE_W-1:0]   avs_byteenable_i;
   logic [1:0]        avs_response_o, mode;
   logic              avs_waitrequest_o, low_side_switch_on_o, keep, fifo;
   csc_apply_s        apply_o;
   logic [CFG_W-1:0]  cfg [NUM_CHAN];
   logic [CHAN_W-1:0] cur, last;
   logic [DATA_W-1:0] exp_q [$];
   int                miscompares, comparisons;
   csc_top csc_top_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_response_o(avs_response_o), .avs_waitrequest_o(avs_waitrequest_o),
      .conv_done_i(conv_done_i), .apply_o(apply_o), .low_side_switch_on_o(low_side_switch_on_o));
   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
      comparisons++;
      if (seen !== want) begin
         miscompares++;
         $display("MISMATCH at %0t: saw %h, want %h", $time, seen, want);
      end
   endtask : check
   // Holds the request until waitrequest is seen low, then lets one edge pass
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      input logic [3:0] b);
      avs_address_i <= a;
      avs_writedata_i <= wd;
      avs_byteenable_i <= b;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      // Only the watchdog ends a wait that never gets its answer
      do begin
         @(posedge ref_clk_i);
      end while (avs_waitrequest_o !== 1'b0);
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] w);
      exp_q.push_back(w);
      bus(1'b0, a, 32'h0, 4'hF);
   endtask : rd
   function automatic logic [7:0] ca(input int m);
      return 8'((IDX_CHAN_FIRST + m) << IDX_LSB);
   endfunction : ca
   function automatic logic [CHAN_W-1:0] nxt(input logic [CHAN_W-1:0] c);
      for (int k = 1; k <= NUM_CHAN; k++)
         if (cfg[(c + k) % NUM_CHAN][23]) return CHAN_W'((c + k) % NUM_CHAN);
      return c;
   endfunction : nxt
   always @(posedge ref_clk_i) begin
      if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0)
         check(avs_readdata_o, exp_q.pop_front());
   end
   task automatic step;
      logic sw;
      conv_done_i <= 1'b1;
      @(posedge ref_clk_i);
      conv_done_i <= 1'b0;
      if (mode == MODE_ACTIVE) begin
         last = cur;
         cur = nxt(cur);
      end
      repeat (2) @(posedge ref_clk_i);
      check(32'(apply_o.chan), 32'(cur));
      check(32'(apply_o.valid), 32'(cfg[cur][23]));
      check(32'(apply_o.setup_sel), 32'(cfg[cur][22:20]));
      check(32'(apply_o.positive_input_select), 32'(cfg[cur][17:13]));
      check(32'(apply_o.threshold_watch_enable), 32'(cfg[cur][18] & fifo));
      sw = cfg[cur][19] & cfg[cur][23] & (mode == MODE_ACTIVE | (mode == MODE_STANDBY & keep));
      check(32'(low_side_switch_on_o), 32'(sw));
      rd(8'h80, {24'h0, cur, last});
   endtask : step
   initial begin
      resetn_i = 1'b0;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      conv_done_i = 1'b0;
      avs_address_i = 8'h0;
      avs_writedata_i = 32'h0;
      avs_byteenable_i = 4'h0;
      void'($urandom(32'h553B));
      for (int m = 0; m < NUM_CHAN; m++) cfg[m] = (m == 0) ? CFG_RST_CH0 : CFG_RST;
      cur = 4'h0;
      last = 4'h0;
      mode = MODE_ACTIVE;
      keep = 1'b0;
      fifo = 1'b0;
      repeat (5) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      @(posedge ref_clk_i);
      for (int m = 0; m < NUM_CHAN; m++) rd(ca(m), 32'(cfg[m]));
      rd(8'h20, 32'h0);
      bus(1'b1, 8'h64, 32'hFFFFFFFF, 4'hF);
      rd(8'h64, 32'h0);
      for (int m = 0; m < NUM_CHAN; m++) begin
         d = $urandom;
         d[23] = (m % 3 != 1);
         d[22:20] = 3'(m); // Every setup code, each shared by two channels
         d[19] = (m % 2 == 0);
         bus(1'b1, ca(m), d, 4'hF);
         cfg[m] = d[CFG_W-1:0];
         rd(ca(m), {8'h0, d[23:0]});
      end
      // A single middle lane changes only its own byte
      d = $urandom;
      bus(1'b1, ca(5), d, 4'h2);
      cfg[5][15:8] = d[15:8];
      rd(ca(5), 32'(cfg[5]));
      fifo = 1'b1;
      bus(1'b1, 8'h84, 32'h8, 4'h1);
      repeat (20) step;
      while (!cfg[cur][19]) step;
      // Every low-power mode with and without the standby keep bit, then back to active
      for (int md = 1; md < 5; md++) begin
         for (int kp = 0; kp < 2; kp++) begin
            mode = 2'(md % 4);
            keep = kp[0];
            bus(1'b1, 8'h84, 32'({fifo, keep, mode}), 4'h1);
            step;
         end
      end
      // FIFO off masks threshold watch; restart returns to the lowest enabled channel
      fifo = 1'b0;
      keep = 1'b0;
      bus(1'b1, 8'h84, 32'h0, 4'h1);
      step;
      bus(1'b1, 8'h84, 32'h10, 4'h1);
      cur = nxt(4'hF);
      // Control write without lane 0 is ignored; restart reads back zero
      bus(1'b1, 8'h84, 32'h2, 4'hE);
      rd(8'h84, 32'h0);
      step;
      final_report;
   end
   initial begin
      repeat (5000) @(posedge ref_clk_i);
      miscompares++;
      final_report;
   end
endmodule : testbench
`default_nettype wire
